// >>> pkg/gpio_port_pkg.sv
// Shared constants and types for the eight-bit shared-pin port.
`default_nettype none
package gpio_port_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_PIN_LEVEL = 5'h00;
    localparam logic [4:0] OFF_OUTPUT_LATCH = 5'h04;
    localparam logic [4:0] OFF_DIRECTION = 5'h08;
    localparam logic [4:0] OFF_ANALOG_SEL = 5'h0C;
    localparam logic [4:0] OFF_ALT_CONFIG = 5'h10;

    // ----------------------------------------------------------------
    // Reset values and field layout
    // ----------------------------------------------------------------
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] ANALOG_RST = 8'h2F;
    localparam logic [7:0] ANALOG_MASK = 8'h2F;
    localparam logic [2:0] ALT_CONFIG_RST = 3'h0;
    localparam int ALT_CMP_REF_POS = 0;
    localparam int ALT_CMP1_ROUTE_POS = 1;
    localparam int ALT_CMP2_ROUTE_POS = 2;
    localparam int BIT_CMP_REF = 2;
    localparam int BIT_TIMER_CLK = 4;
    localparam int BIT_CMP2_OUT = 5;
    localparam int BIT_OSC_OUT = 6;
    localparam int BIT_OSC_IN = 7;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLKOUT_DIVIDE = 4;

    // ----------------------------------------------------------------
    // Oscillator configuration codes
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        OSC_LP = 4'h0,
        OSC_XT = 4'h1,
        OSC_HS = 4'h2,
        OSC_RC_CLKOUT = 4'h3,
        OSC_RC_PIN_FREE = 4'h4,
        OSC_INT_CLKOUT = 4'h5,
        OSC_INT_PIN_FREE = 4'h6,
        OSC_EXT_CLKOUT = 4'h7,
        OSC_EXT_PIN_FREE = 4'h8
    } osc_mode_t;

    typedef struct packed {
        logic cmp2_route;
        logic cmp1_route;
        logic cmp_ref_out_en;
    } alt_config_t;

    typedef struct packed {
        logic [7:0] out_val;
        logic [7:0] out_en_n;
    } pin_drive_t;

endpackage
`default_nettype wire

// >>> verilog/avalon_wait_slave.sv
// Avalon-MM handshake: one wait cycle, then a one-cycle acknowledge.
`timescale 1ns/100ps
`default_nettype none
module avalon_wait_slave (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic read,
    input wire logic write,
    output logic waitrequest,
    output logic capture,
    output logic commit
);

    logic waitrequest_q;
    logic waitrequest_d;
    logic request;

    // ----------------------------------------------------------------
    // Handshake
    // ----------------------------------------------------------------
    // The first cycle of a request loads read data; the second, with
    // waitrequest low, is the only edge on which a write commits.
    always_comb begin
        request = read | write;
        capture = request & waitrequest_q;
        commit = request & ~waitrequest_q;
        waitrequest_d = ~capture;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            waitrequest_q <= 1'b1;
        end else begin
            waitrequest_q <= waitrequest_d;
        end
    end

    assign waitrequest = waitrequest_q;

endmodule // avalon_wait_slave
`default_nettype wire

// >>> verilog/cycle_clock_divider.sv
// Divider that makes the instruction cycle clock from the system clock.
`timescale 1ns/100ps
`default_nettype none
module cycle_clock_divider
    import gpio_port_pkg::*;
#(
    parameter int DIVIDE = CLKOUT_DIVIDE
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic enable,
    output logic clk_out
);

    localparam int CNT_W = $clog2(DIVIDE);

    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic clk_out_q;
    logic clk_out_d;

    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    // Held at zero while disabled so the output always starts low.
    always_comb begin
        count_d = '0;
        clk_out_d = 1'b0;
        if (enable) begin
            if (count_q == CNT_W'(DIVIDE - 1)) begin
                count_d = '0;
            end else begin
                count_d = count_q + CNT_W'(1);
            end
            clk_out_d = (count_d >= CNT_W'(DIVIDE / 2));
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count_q <= '0;
            clk_out_q <= 1'b0;
        end else begin
            count_q <= count_d;
            clk_out_q <= clk_out_d;
        end
    end

    assign clk_out = clk_out_q;

endmodule // cycle_clock_divider
`default_nettype wire

// >>> verilog/shared_pin_port.sv
// Eight-bit general purpose port whose pins are shared with analog and clock functions.
`timescale 1ns/100ps
`default_nettype none
module shared_pin_port
    import gpio_port_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe_n,
    input wire logic [3:0] osc_mode,
    input wire logic comparator_one_result,
    input wire logic comparator_two_result,
    output logic timer_ext_clock_in,
    output logic cmp_ref_voltage_out,
    output logic [WIDTH-1:0] analog_sel
);

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic osc_out_pin_free(input logic [3:0] mode);
        osc_out_pin_free = (mode == OSC_RC_PIN_FREE) || (mode == OSC_INT_PIN_FREE) ||
            (mode == OSC_EXT_PIN_FREE);
    endfunction

    function automatic logic osc_out_is_clock(input logic [3:0] mode);
        osc_out_is_clock = (mode == OSC_RC_CLKOUT) || (mode == OSC_INT_CLKOUT) ||
            (mode == OSC_EXT_CLKOUT);
    endfunction

    // The input pin stays free only while the internal oscillator runs.
    function automatic logic osc_in_pin_free(input logic [3:0] mode);
        osc_in_pin_free = (mode == OSC_INT_CLKOUT) || (mode == OSC_INT_PIN_FREE);
    endfunction

    // Mask of bits usable as general I/O under a given oscillator mode.
    function automatic logic [WIDTH-1:0] io_mask(input logic [3:0] mode);
        logic [WIDTH-1:0] m;
        m = '1;
        m[BIT_OSC_OUT] = osc_out_pin_free(mode);
        m[BIT_OSC_IN] = osc_in_pin_free(mode);
        io_mask = m;
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] latch_d;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] dir_d;
    logic [WIDTH-1:0] analog_q;
    logic [WIDTH-1:0] analog_d;
    alt_config_t alt_q;
    alt_config_t alt_d;
    logic [31:0] readdata_q;
    logic [31:0] readdata_d;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] level_d;
    logic [3:0] osc_q;
    logic [3:0] osc_d;
    pin_drive_t drive_q;
    pin_drive_t drive_d;
    logic timer_clk_q;
    logic timer_clk_d;
    logic capture;
    logic commit;
    logic write_lane;
    logic cycle_clock;
    logic clkout_en;
    logic [WIDTH-1:0] usable;
    logic [WIDTH-1:0] din_en;
    logic [WIDTH-1:0] level_view;

    // ----------------------------------------------------------------
    // Bus handshake and cycle clock
    // ----------------------------------------------------------------
    avalon_wait_slave u_handshake (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .read(read),
        .write(write),
        .waitrequest(waitrequest),
        .capture(capture),
        .commit(commit)
    );

    assign clkout_en = osc_out_is_clock(osc_q);

    cycle_clock_divider #(
        .DIVIDE(CLKOUT_DIVIDE)
    ) u_cycle_clock (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .enable(clkout_en),
        .clk_out(cycle_clock)
    );

    // ----------------------------------------------------------------
    // Digital input enables and visible pin levels
    // ----------------------------------------------------------------
    always_comb begin
        usable = io_mask(osc_q);
        din_en = usable & ~analog_q;
        if (alt_q.cmp_ref_out_en) begin
            din_en[BIT_CMP_REF] = 1'b0;
        end
        level_view = level_q & din_en;
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    // Only byte lane 0 carries data; a write with that lane off is dropped.
    always_comb begin
        write_lane = commit & write & byteenable[0];
        latch_d = latch_q;
        dir_d = dir_q;
        analog_d = analog_q;
        alt_d = alt_q;
        if (write_lane) begin
            case (address)
                OFF_PIN_LEVEL: begin
                    latch_d = writedata[WIDTH-1:0];
                end
                OFF_OUTPUT_LATCH: begin
                    latch_d = writedata[WIDTH-1:0];
                end
                OFF_DIRECTION: begin
                    dir_d = writedata[WIDTH-1:0];
                end
                OFF_ANALOG_SEL: begin
                    analog_d = writedata[WIDTH-1:0] & ANALOG_MASK;
                end
                OFF_ALT_CONFIG: begin
                    alt_d = alt_config_t'(writedata[2:0]);
                end
                default: begin
                    latch_d = latch_q;
                end
            endcase
        end
    end

    // Analog selection comes up set on bits 0-3 and 5, clear on bit 4.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            latch_q <= LATCH_RST;
            dir_q <= DIR_RST;
            analog_q <= ANALOG_RST;
            alt_q <= ALT_CONFIG_RST;
        end else begin
            latch_q <= latch_d;
            dir_q <= dir_d;
            analog_q <= analog_d;
            alt_q <= alt_d;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Read data is loaded on the first request edge and held until the
    // next read, so it is stable while waitrequest is low.
    always_comb begin
        readdata_d = readdata_q;
        if (capture && read) begin
            readdata_d = '0;
            case (address)
                OFF_PIN_LEVEL: begin
                    readdata_d[WIDTH-1:0] = level_view;
                end
                OFF_OUTPUT_LATCH: begin
                    readdata_d[WIDTH-1:0] = latch_q & usable;
                end
                OFF_DIRECTION: begin
                    readdata_d[WIDTH-1:0] = dir_q & usable;
                end
                OFF_ANALOG_SEL: begin
                    readdata_d[WIDTH-1:0] = analog_q;
                end
                OFF_ALT_CONFIG: begin
                    readdata_d[2:0] = alt_q;
                end
                default: begin
                    readdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            readdata_q <= '0;
        end else begin
            readdata_q <= readdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive and sampling
    // ----------------------------------------------------------------
    // Pin levels pass one flip-flop before software sees them; the pins
    // are taken as already synchronous to clk_sys.
    always_comb begin
        level_d = pin_in;
        osc_d = osc_mode;
        timer_clk_d = pin_in[BIT_TIMER_CLK];
        drive_d.out_val = '0;
        drive_d.out_en_n = '1;
        for (int i = 0; i < WIDTH; i++) begin
            if (usable[i] && !dir_q[i]) begin
                drive_d.out_val[i] = latch_q[i];
                drive_d.out_en_n[i] = 1'b0;
            end
        end
        if (!dir_q[BIT_TIMER_CLK] && alt_q.cmp1_route) begin
            drive_d.out_val[BIT_TIMER_CLK] = comparator_one_result;
        end
        if (!dir_q[BIT_CMP2_OUT] && alt_q.cmp2_route) begin
            drive_d.out_val[BIT_CMP2_OUT] = comparator_two_result;
        end
        // The reference output is analog; the digital driver must let go.
        if (alt_q.cmp_ref_out_en) begin
            drive_d.out_val[BIT_CMP_REF] = 1'b0;
            drive_d.out_en_n[BIT_CMP_REF] = 1'b1;
        end
        if (clkout_en) begin
            drive_d.out_val[BIT_OSC_OUT] = cycle_clock;
            drive_d.out_en_n[BIT_OSC_OUT] = 1'b0;
        end
        if (!usable[BIT_OSC_IN]) begin
            drive_d.out_val[BIT_OSC_IN] = 1'b0;
            drive_d.out_en_n[BIT_OSC_IN] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            level_q <= '0;
            osc_q <= OSC_LP;
            timer_clk_q <= 1'b0;
            drive_q.out_val <= '0;
            drive_q.out_en_n <= '1;
        end else begin
            level_q <= level_d;
            osc_q <= osc_d;
            timer_clk_q <= timer_clk_d;
            drive_q <= drive_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign readdata = readdata_q;
    assign pin_out = drive_q.out_val;
    assign pin_oe_n = drive_q.out_en_n;
    assign timer_ext_clock_in = timer_clk_q;
    assign cmp_ref_voltage_out = alt_q.cmp_ref_out_en;
    assign analog_sel = analog_q;

endmodule // shared_pin_port
`default_nettype wire

// >>> verif/pin_partner.sv
// Behavioural model of the board wiring on the eight port pins.
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] ext_drive,
    output logic [7:0] pin_in
);
    // ----------------------------------------------------------------
    // Pin resolution
    // ----------------------------------------------------------------
    // An outside driver holds every released pin, so no line is left to settle on its own.
    assign pin_in = (pin_out & ~pin_oe_n) | (ext_drive & pin_oe_n);
endmodule // pin_partner
`default_nettype wire

// >>> verif/shared_pin_port_chk.sv
// Concurrent checks on the ports of the shared-pin port.
`timescale 1ns/100ps
`default_nettype none
module shared_pin_port_chk
    import gpio_port_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [WIDTH-1:0] pin_in,
    input wire logic [WIDTH-1:0] pin_out,
    input wire logic [WIDTH-1:0] pin_oe_n,
    input wire logic [3:0] osc_mode,
    input wire logic comparator_one_result,
    input wire logic comparator_two_result,
    input wire logic timer_ext_clock_in,
    input wire logic cmp_ref_voltage_out,
    input wire logic [WIDTH-1:0] analog_sel
);
    // ----------------------------------------------------------------
    // Mode settle counter
    // ----------------------------------------------------------------
    // Pin checks wait for the mode to settle, since the design samples it with latency.
    // They read the next count, so the edge that first sees a new mode already counts as zero.
    logic [3:0] stab_q;
    logic [3:0] stab_d;
    logic [3:0] osc_prev_q;
    logic clkout_m;
    assign clkout_m = osc_mode inside {OSC_RC_CLKOUT, OSC_INT_CLKOUT, OSC_EXT_CLKOUT};
    always_comb begin
        stab_d = stab_q;
        if (osc_mode != osc_prev_q) begin
            stab_d = 4'h0;
        end else if (stab_q != 4'hF) begin
            stab_d = stab_q + 4'h1;
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            stab_q <= 4'h0;
            osc_prev_q <= 4'h0;
        end else begin
            stab_q <= stab_d;
            osc_prev_q <= osc_mode;
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_ack_in_time: assert property ((read || write) |-> ##[0:1] !waitrequest)
        else $error("Request not acknowledged in time.");
    a_ack_single: assert property (!waitrequest |=> waitrequest)
        else $error("Acknowledge longer than one cycle.");
    a_idle_waits: assert property (!read && !write |-> waitrequest)
        else $error("Acknowledge without a request.");
    a_ref_blocks_pin: assert property (cmp_ref_voltage_out && $past(cmp_ref_voltage_out)
        |-> pin_oe_n[BIT_CMP_REF]) else $error("Bit 2 driven while reference output is on.");
    a_clk_quarter: assert property (stab_d == 4'hF && clkout_m |-> !pin_oe_n[BIT_OSC_OUT]
        && (pin_out[BIT_OSC_OUT] != $past(pin_out[BIT_OSC_OUT], 2)))
        else $error("Cycle clock output wrong.");
    a_osc_out_busy: assert property (stab_d >= 4'h4 && osc_mode inside {4'h0, 4'h1, 4'h2}
        |-> pin_oe_n[BIT_OSC_OUT]) else $error("Bit 6 driven in crystal mode.");
    a_osc_in_busy: assert property (stab_d >= 4'h4 && !(osc_mode inside {4'h5, 4'h6})
        |-> pin_oe_n[BIT_OSC_IN]) else $error("Bit 7 driven in oscillator mode.");
    a_timer_follows: assert property ($past(resetn)
        |-> timer_ext_clock_in == $past(pin_in[BIT_TIMER_CLK])) else $error("Timer input lags.");
    a_analog_boot: assert property ($rose(resetn) |-> analog_sel == ANALOG_RST)
        else $error("Analog selection wrong after reset.");
    c_read: cover property (read && !waitrequest);
    c_write: cover property (write && !waitrequest);
    c_clkout: cover property (stab_d == 4'hF && clkout_m);
    c_ref: cover property (cmp_ref_voltage_out && pin_oe_n[BIT_CMP_REF]);
endmodule // shared_pin_port_chk
bind shared_pin_port shared_pin_port_chk #(.WIDTH(WIDTH)) u_chk (.clk_sys(clk_sys),
    .resetn(resetn), .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .osc_mode(osc_mode),
    .comparator_one_result(comparator_one_result), .comparator_two_result(comparator_two_result),
    .timer_ext_clock_in(timer_ext_clock_in), .cmp_ref_voltage_out(cmp_ref_voltage_out),
    .analog_sel(analog_sel));
`default_nettype wire

// >>> verif/eight_bit_port_with_pin_sharing_tb.sv
// Self-checking testbench for the shared-pin port.
`timescale 1ns/100ps
`default_nettype none
module eight_bit_port_with_pin_sharing_tb;
    import gpio_port_pkg::*;
    logic clk_sys, resetn, read, write, waitrequest, comparator_one_result, comparator_two_result;
    logic timer_ext_clock_in, cmp_ref_voltage_out;
    logic [4:0] address;
    logic [31:0] writedata, readdata, q;
    logic [3:0] byteenable, osc_mode, mode;
    logic [7:0] pin_in, pin_out, pin_oe_n, analog_sel, ext_q, lat, dir, ana, oen, drv, pins, msk;
    logic [2:0] alt;
    integer seed;
    int error_cnt, checks_done, i;
    shared_pin_port u_shared_pin_port (.clk_sys(clk_sys), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .osc_mode(osc_mode), .comparator_one_result(comparator_one_result),
        .comparator_two_result(comparator_two_result), .timer_ext_clock_in(timer_ext_clock_in),
        .cmp_ref_voltage_out(cmp_ref_voltage_out), .analog_sel(analog_sel));
    pin_partner u_pin_partner (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_drive(ext_q),
        .pin_in(pin_in));
    always #25 clk_sys = ~clk_sys;
    // ----------------------------------------------------------------
    // Expectation functions
    // ----------------------------------------------------------------
    function automatic logic [7:0] io_mask(input logic [3:0] m);
        io_mask = 8'h3F;
        io_mask[6] = m inside {OSC_RC_PIN_FREE, OSC_INT_PIN_FREE, OSC_EXT_PIN_FREE};
        io_mask[7] = m inside {OSC_INT_CLKOUT, OSC_INT_PIN_FREE};
    endfunction
    function automatic logic is_clkout(input logic [3:0] m);
        is_clkout = m inside {OSC_RC_CLKOUT, OSC_INT_CLKOUT, OSC_EXT_CLKOUT};
    endfunction
    function automatic logic [7:0] exp_oen(input logic [7:0] d, input logic [2:0] a,
                                           input logic [3:0] m);
        exp_oen = d | ~io_mask(m);
        exp_oen[2] = exp_oen[2] | a[0];
        if (is_clkout(m)) exp_oen[6] = 1'b0;
    endfunction
    // ----------------------------------------------------------------
    // Bus and report tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // The request stands until a rising edge samples waitrequest low; only the watchdog ends a hang.
    task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        address <= a;
        writedata <= {24'h0, d};
        write <= we;
        read <= !we;
        do begin
            @(posedge clk_sys);
        end while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic end_of_test;
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        end_of_test();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0; resetn = 1'b0; address = 5'h00; read = 1'b0; write = 1'b0;
        writedata = 32'h0; byteenable = 4'hF; osc_mode = OSC_INT_PIN_FREE; ext_q = 8'hA5;
        comparator_one_result = 1'b0; comparator_two_result = 1'b0; seed = 83;
        error_cnt = 0; checks_done = 0;
        repeat (8) @(posedge clk_sys);
        resetn <= 1'b1;
        @(negedge clk_sys);
        check(pin_oe_n, 8'hFF);
        bus(0, OFF_PIN_LEVEL, 8'h00); check(q, ext_q & 8'hD0);
        bus(0, OFF_DIRECTION, 8'h00); check(q, DIR_RST);
        bus(0, OFF_OUTPUT_LATCH, 8'h00); check(q, LATCH_RST);
        bus(0, OFF_ANALOG_SEL, 8'h00); check(q, ANALOG_RST);
        bus(1, OFF_PIN_LEVEL, 8'h3C);
        bus(0, OFF_OUTPUT_LATCH, 8'h00); check(q, 8'h3C);
        byteenable <= 4'h0;
        bus(1, OFF_OUTPUT_LATCH, 8'hFF);
        byteenable <= 4'hF;
        bus(1, 5'h14, 8'h77);
        bus(0, 5'h14, 8'h00); check(q, 32'h0);
        bus(0, OFF_OUTPUT_LATCH, 8'h00); check(q, 8'h3C);
        // The first nine passes step through every oscillator code in turn.
        for (i = 0; i < 24; i++) begin
            mode = (i < 9) ? i[3:0] : 4'($unsigned($random(seed)) % 9);
            lat = 8'($random(seed));
            dir = (i == 0) ? 8'h00 : 8'($random(seed));
            ana = (i == 0) ? 8'hFF : 8'($random(seed));
            alt = 3'($random(seed));
            osc_mode <= mode;
            ext_q <= 8'($random(seed));
            comparator_one_result <= 1'($random(seed));
            comparator_two_result <= 1'($random(seed));
            bus(1, OFF_OUTPUT_LATCH, lat);
            bus(1, OFF_DIRECTION, dir);
            bus(1, OFF_ANALOG_SEL, ana);
            bus(1, OFF_ALT_CONFIG, {5'h0, alt});
            repeat (3) @(posedge clk_sys);
            @(negedge clk_sys);
            oen = exp_oen(dir, alt, mode);
            drv = lat;
            if (alt[1] && !dir[4]) drv[4] = comparator_one_result;
            if (alt[2] && !dir[5]) drv[5] = comparator_two_result;
            msk = ~oen;
            if (is_clkout(mode)) msk[6] = 1'b0;
            pins = (drv & ~oen) | (ext_q & oen);
            check(pin_oe_n, oen);
            check(pin_out & msk, drv & msk);
            check(analog_sel, ana & ANALOG_MASK);
            check(cmp_ref_voltage_out, alt[0]);
            check(timer_ext_clock_in, pins[4]);
            bus(0, OFF_PIN_LEVEL, 8'h00);
            check(q, pins & io_mask(mode) & ~(ana & ANALOG_MASK) & ~{5'h0, alt[0], 2'h0});
            bus(0, OFF_OUTPUT_LATCH, 8'h00); check(q, lat & io_mask(mode));
            bus(0, OFF_DIRECTION, 8'h00); check(q, dir & io_mask(mode));
            bus(0, OFF_ALT_CONFIG, 8'h00); check(q, {5'h0, alt});
        end
        end_of_test();
    end
endmodule // eight_bit_port_with_pin_sharing_tb
`default_nettype wire
